// ---- rtl/isahp_params.svh ----
// Constants for the ISA slave host port: register offsets, lane decode and timing counts.
// Assumes inclusion by bare name from the package and the port logic.
`ifndef ISAHP_PARAMS_SVH
`define ISAHP_PARAMS_SVH

`define ISAHP_ADDR_W         5
`define ISAHP_LANE_W         8
`define ISAHP_FIFO_WORD_ADDR 5'h18
`define ISAHP_LEGACY_MASK    32'hA8AA5555
`define ISAHP_RD_SETTLE      2'h2
`define ISAHP_BUF_DEPTH      2
`define ISAHP_SYNC_W         37

`endif

// ---- rtl/isahp_pkg.sv ----
// Types shared by the ISA slave host port and its helpers.
// Assumes isahp_params.svh is on the include path.
`include "isahp_params.svh"

package isahp_pkg;

   typedef struct packed {
      logic [`ISAHP_ADDR_W-1:0] addr;
      logic [`ISAHP_LANE_W-1:0] upper;
      logic [`ISAHP_LANE_W-1:0] lower;
      logic                     up_en;
      logic                     lo_en;
   } isahp_wr_s;

   typedef struct packed {
      logic [`ISAHP_LANE_W-1:0] upper;
      logic [`ISAHP_LANE_W-1:0] lower;
   } isahp_rd_s;

   typedef enum logic [2:0] {
      ISAHP_IDLE  = 3'h1,
      ISAHP_READ  = 3'h2,
      ISAHP_WRITE = 3'h4
   } isahp_state_e;

endpackage : isahp_pkg

// ---- rtl/isahp_sync.sv ----
// Two-flop synchroniser for a vector of pin inputs.
// Assumes each bit is an independent level from outside the ref_clk domain.
`timescale 1ns/1ns

module isahp_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk, // System clock
   input  wire logic [W-1:0] din,     // Asynchronous pin levels
   output logic      [W-1:0] dout     // Synchronised levels
);
   logic [W-1:0] meta_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge ref_clk) begin
            meta_q[i] <= din[i];
            dout[i]   <= meta_q[i];
         end
      end
   endgenerate

endmodule : isahp_sync

// ---- rtl/isahp_buf.sv ----
// Small FIFO buffer with valid/ready on both sides; full and empty are exact.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns

module isahp_buf #(
   parameter int W     = 8,
   parameter int DEPTH = 2
) (
   input  wire logic         ref_clk,   // System clock
   input  wire logic         srst,      // Synchronous reset
   input  wire logic [W-1:0] in_data,   // Word to store
   input  wire logic         in_valid,  // Store request
   output logic              in_ready,  // Room for a word
   output logic      [W-1:0] out_data,  // Oldest word
   output logic              out_valid, // Oldest word present
   input  wire logic         out_ready  // Drain accepts
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0]  mem_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [PW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + PW'(1);
         end
         if (pop) begin
            rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + PW'(1);
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

endmodule : isahp_buf

// ---- rtl/isahp_port.sv ----
// ISA slave host port: base decode, register select, byte-lane steering, strobe timing.
// Assumes a register file on ref_clk that answers rd_addr combinationally on rd_data,
// and drains written words from the buffer. All ISA pins are asynchronous to ref_clk.
`timescale 1ns/1ns
`include "isahp_params.svh"

module isahp_port #(
   parameter int BUF_DEPTH = `ISAHP_BUF_DEPTH
) (
   input  wire logic                         ref_clk,               // 10 MHz system clock
   input  wire logic                         srst,                  // Synchronous reset, high
   input  wire logic [7:0]                   upper_data_lane_i,     // Upper lane pin level
   input  wire logic [7:0]                   lower_data_lane_i,     // Lower lane pin level
   output logic      [7:0]                   upper_data_lane_o,     // Upper lane drive value
   output logic      [7:0]                   lower_data_lane_o,     // Lower lane drive value
   output logic                              upper_lane_drive_en_n, // Upper lane driven, low
   output logic                              lower_lane_drive_en_n, // Lower lane driven, low
   input  wire logic                         high_byte_enable_n,    // High byte enable, low
   input  wire logic                         slot_width_sense,      // High in narrow slot
   input  wire logic [4:0]                   base_addr_in,          // Upper address bits
   input  wire logic [4:0]                   base_select_switch,    // Base address switches
   input  wire logic                         address_enable_n,      // Address enable, low
   input  wire logic [4:0]                   reg_select,            // Register select bits
   input  wire logic                         io_read_n,             // I/O read strobe, low
   input  wire logic                         io_write_n,            // I/O write strobe, low
   input  wire logic                         dma_ack_n,             // DMA acknowledge, low
   input  wire logic                         legacy_mode,           // Legacy mode from core
   output logic                              chan_ready_o,          // Channel ready drive level
   output logic                              chan_ready_oe_n,       // Channel ready pulled low
   output logic                              wide_cycle_ack_n_o,    // Wide ack drive level
   output logic                              wide_cycle_ack_oe_n,   // Wide ack pulled low
   output logic      [`ISAHP_ADDR_W-1:0]     rd_addr,               // Register being read
   output logic                              rd_req,                // Read in progress
   input  wire isahp_pkg::isahp_rd_s         rd_data,               // Register read value
   output logic                              rd_done,               // Read ended, one cycle
   output logic      [`ISAHP_ADDR_W-1:0]     rd_done_addr,          // Register of ended read
   output isahp_pkg::isahp_wr_s              wr_word,               // Buffered write
   output logic                              wr_valid,              // Buffered write present
   input  wire logic                         wr_ready               // Register file accepts
);
   import isahp_pkg::*;

   logic [`ISAHP_SYNC_W-1:0] raw;
   logic [`ISAHP_SYNC_W-1:0] syn;
   logic [7:0]               s_up;
   logic [7:0]               s_lo;
   logic                     s_bhe_n;
   logic                     s_sense;
   logic [4:0]               s_base;
   logic [4:0]               s_sw;
   logic                     s_address_enable_n;
   logic [4:0]               s_reg;
   logic                     s_rd_n;
   logic                     s_wr_n;
   logic                     s_dack_n;

   // Every pin, data lanes included, passes the two-flop synchroniser
   assign raw = {upper_data_lane_i, lower_data_lane_i, high_byte_enable_n, slot_width_sense,
                 base_addr_in, base_select_switch, address_enable_n, reg_select,
                 io_read_n, io_write_n, dma_ack_n};

   isahp_sync #(.W(`ISAHP_SYNC_W)) u_sync (
      .ref_clk (ref_clk),
      .din     (raw),
      .dout    (syn)
   );

   assign {s_up, s_lo, s_bhe_n, s_sense, s_base, s_sw, s_address_enable_n, s_reg, s_rd_n, s_wr_n, s_dack_n} = syn;

   // Decode of the current cycle
   logic                     dma_c;
   logic                     cs_c;
   logic                     sel_c;
   logic [`ISAHP_ADDR_W-1:0] addr_c;
   logic                     word_c;
   logic                     up_c;
   logic                     lo_c;
   logic                     rd_c;
   logic                     wr_c;
   logic                     legacy_c;
   logic [31:0]              legacy_mask;

   // Bit n of the mask marks offset n as a legacy-controller register
   assign legacy_mask = `ISAHP_LEGACY_MASK;
   assign dma_c  = !s_dack_n;
   assign cs_c   = !s_address_enable_n && (s_base == s_sw) && !dma_c;
   assign sel_c  = cs_c || dma_c;
   assign addr_c = dma_c ? `ISAHP_FIFO_WORD_ADDR : s_reg;
   assign word_c = dma_c || (!s_sense && !s_bhe_n && (s_reg == `ISAHP_FIFO_WORD_ADDR));
   assign up_c   = word_c || (!s_sense && !s_bhe_n && s_reg[0]);
   assign lo_c   = word_c || s_bhe_n;
   assign rd_c   = sel_c && !s_rd_n;
   assign wr_c   = sel_c && !s_wr_n;
   assign legacy_c = legacy_mode && cs_c && legacy_mask[s_reg];

   // Access sequencer
   isahp_state_e             state_q;
   logic [`ISAHP_ADDR_W-1:0] acc_addr_q;
   logic                     acc_up_q;
   logic                     acc_lo_q;
   logic [7:0]               wd_up_q;
   logic [7:0]               wd_lo_q;
   logic [1:0]               age_q;
   logic                     push;
   logic                     buf_in_ready;
   isahp_wr_s                push_word;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_q <= ISAHP_IDLE;
      end else begin
         case (state_q)
            ISAHP_IDLE: begin
               if (rd_c) begin
                  state_q <= ISAHP_READ;
               end else if (wr_c) begin
                  state_q <= ISAHP_WRITE;
               end
            end
            ISAHP_READ: begin
               if (!rd_c) begin
                  state_q <= ISAHP_IDLE;
               end
            end
            ISAHP_WRITE: begin
               if (!wr_c) begin
                  state_q <= ISAHP_IDLE;
               end
            end
            default: state_q <= ISAHP_IDLE;
         endcase
      end
   end

   // Access attributes follow the decode while the strobe is low
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         acc_addr_q <= '0;
         acc_up_q   <= 1'b0;
         acc_lo_q   <= 1'b0;
         wd_up_q    <= '0;
         wd_lo_q    <= '0;
      end else if (rd_c || wr_c) begin
         acc_addr_q <= addr_c;
         acc_up_q   <= up_c;
         acc_lo_q   <= lo_c;
         wd_up_q    <= s_up;
         wd_lo_q    <= s_lo;
      end
   end

   // Counts read cycles so a legacy read releases channel ready once its data has settled
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         age_q <= '0;
      end else if (state_q != ISAHP_READ) begin
         age_q <= '0;
      end else if (age_q != `ISAHP_RD_SETTLE) begin
         age_q <= age_q + 2'h1;
      end
   end

   // Write lands when the strobe rises; disabled lanes carry no data
   assign push = (state_q == ISAHP_WRITE) && !wr_c;
   assign push_word = '{addr:  acc_addr_q,
                        upper: acc_up_q ? wd_up_q : '0,
                        lower: acc_lo_q ? wd_lo_q : '0,
                        up_en: acc_up_q,
                        lo_en: acc_lo_q};

   isahp_buf #(.W($bits(isahp_wr_s)), .DEPTH(BUF_DEPTH)) u_buf (
      .ref_clk   (ref_clk),
      .srst      (srst),
      .in_data   (push_word),
      .in_valid  (push),
      .in_ready  (buf_in_ready),
      .out_data  (wr_word),
      .out_valid (wr_valid),
      .out_ready (wr_ready)
   );

   // Read lanes and their enables
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         upper_lane_drive_en_n <= 1'b1;
         lower_lane_drive_en_n <= 1'b1;
         upper_data_lane_o     <= '0;
         lower_data_lane_o     <= '0;
      end else begin
         upper_lane_drive_en_n <= !(rd_c && up_c);
         lower_lane_drive_en_n <= !(rd_c && lo_c);
         upper_data_lane_o     <= (rd_c && up_c) ? rd_data.upper : '0;
         lower_data_lane_o     <= (rd_c && lo_c) ? rd_data.lower : '0;
      end
   end

   // rd_addr follows the decode every cycle, so rd_data has settled before the lanes take it
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rd_addr      <= '0;
         rd_req       <= 1'b0;
         rd_done      <= 1'b0;
         rd_done_addr <= '0;
      end else begin
         rd_addr      <= addr_c;
         rd_req       <= rd_c;
         rd_done      <= (state_q == ISAHP_READ) && !rd_c;
         rd_done_addr <= acc_addr_q;
      end
   end

   // Open-collector outputs; the pin level is always low and only the enable moves
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         chan_ready_o        <= 1'b0;
         wide_cycle_ack_n_o  <= 1'b0;
         chan_ready_oe_n     <= 1'b1;
         wide_cycle_ack_oe_n <= 1'b1;
      end else begin
         chan_ready_o        <= 1'b0;
         wide_cycle_ack_n_o  <= 1'b0;
         // Hold the cycle while a full buffer could not take the write, or while a legacy read has not yet settled
         chan_ready_oe_n <= !((wr_c && !buf_in_ready) ||
                              (legacy_c && rd_c &&
                               !((state_q == ISAHP_READ) && (age_q == `ISAHP_RD_SETTLE))));
         // Wide acknowledge needs no strobe: the host samples it from the decoded address
         wide_cycle_ack_oe_n <= !(sel_c && up_c);
      end
   end

   // Checks on select, steering and strobe timing
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   cs_match_a: assert property ($rose(rd_req) && !$past(dma_c) |->
      !$past(s_address_enable_n) && ($past(s_base) == $past(s_sw)))
      else $error("read started without base match");
   dma_addr_a: assert property (rd_req && $past(dma_c) |-> rd_addr == `ISAHP_FIFO_WORD_ADDR)
      else $error("dma read not steered to fifo word");
   wr_rise_a: assert property (push |-> $past(wr_c, 1) && !wr_c && (push_word.addr == acc_addr_q))
      else $error("write pushed without strobe rise");
   rd_hold_a: assert property (rd_c && (up_c || lo_c) ##1 rd_c |=>
      !(upper_lane_drive_en_n && lower_lane_drive_en_n))
      else $error("read strobe low but no lane driven");
   word_lanes_a: assert property (rd_c && word_c |=> !upper_lane_drive_en_n && !lower_lane_drive_en_n)
      else $error("word access did not drive both lanes");
   odd_upper_a: assert property (rd_c && !dma_c && !s_sense && !s_bhe_n && s_reg[0] |=>
      !upper_lane_drive_en_n && lower_lane_drive_en_n)
      else $error("odd wide access lane wrong");
   bhe_lower_a: assert property (rd_c && !dma_c && s_bhe_n |=>
      upper_lane_drive_en_n && !lower_lane_drive_en_n)
      else $error("byte access not on lower lane");
   narrow_slot_a: assert property (sel_c && !dma_c && s_sense && s_bhe_n |=> wide_cycle_ack_oe_n)
      else $error("narrow slot touched upper lane");
   upper_gate_a: assert property (!upper_lane_drive_en_n |-> !$past(s_bhe_n) || $past(dma_c))
      else $error("upper lane without high byte enable");
   idle_lanes_a: assert property (!rd_c |=> upper_lane_drive_en_n && lower_lane_drive_en_n
      && (upper_data_lane_o == '0) && (lower_data_lane_o == '0))
      else $error("lanes active outside read");
   legacy_rel_a: assert property ((state_q == ISAHP_READ) && (age_q == `ISAHP_RD_SETTLE)
      && buf_in_ready |=> chan_ready_oe_n)
      else $error("channel ready held after read data valid");
   wide_ack_a: assert property (sel_c && up_c |=> !wide_cycle_ack_oe_n)
      else $error("wide acknowledge missing on upper access");
   wide_rel_a: assert property (!sel_c |=> wide_cycle_ack_oe_n)
      else $error("wide acknowledge held while deselected");
   reg_only_a: assert property (rd_c && !dma_c |=> rd_addr == $past(s_reg))
      else $error("register choice not from address bits");
   lane_order_a: assert property (!upper_lane_drive_en_n && !lower_lane_drive_en_n |->
      {upper_data_lane_o, lower_data_lane_o} == $past(rd_data))
      else $error("word lanes out of order");
   legacy_hold_a: assert property (legacy_c && rd_c && (state_q == ISAHP_IDLE) |=> !chan_ready_oe_n)
      else $error("legacy read not lengthened");
   dma_no_hold_a: assert property (dma_c && buf_in_ready |=> chan_ready_oe_n)
      else $error("channel ready pulled during dma");
   rd_end_a: assert property (rd_done |-> $past(state_q) == ISAHP_READ)
      else $error("read end without a read");
   wr_ignore_a: assert property (push |-> (push_word.up_en || (push_word.upper == '0))
      && (push_word.lo_en || (push_word.lower == '0)))
      else $error("ignored lane data stored");

   // Main scenarios
   word_read_c: cover property (rd_c && word_c ##1 rd_c [*3] ##1 !rd_c);
   odd_write_c: cover property (push && push_word.up_en && !push_word.lo_en);
   legacy_wait_c: cover property (!chan_ready_oe_n && rd_c ##[1:4] chan_ready_oe_n && rd_c);
   buf_full_c: cover property (!buf_in_ready && wr_c);
   dma_read_c: cover property (rd_c && dma_c ##1 rd_c ##1 !upper_lane_drive_en_n);

endmodule : isahp_port

// ---- test/isahp_host_model.sv ----
// ISA bus master model: drives the host-side pins of the slave port.
// Assumes the bench calls its tasks from one process and resolves the data lanes.
`timescale 1ns/1ns

module isahp_host_model (
   input  wire logic       ref_clk,            // System clock
   input  wire logic       chan_ready_oe_n,    // Channel ready pulled low
   output logic      [7:0] host_upper,         // Upper lane value from host
   output logic      [7:0] host_lower,         // Lower lane value from host
   output logic            high_byte_enable_n, // High byte enable
   output logic            slot_width_sense,   // Narrow slot
   output logic      [4:0] base_addr_in,       // Upper address bits
   output logic            address_enable_n,   // Address enable
   output logic      [4:0] reg_select,         // Register select bits
   output logic            io_read_n,          // Read strobe
   output logic            io_write_n,         // Write strobe
   output logic            dma_ack_n           // DMA acknowledge
);
   initial begin
      host_upper         = 8'hFF;
      host_lower         = 8'hFF;
      high_byte_enable_n = 1'b1;
      slot_width_sense   = 1'b1;
      base_addr_in       = 5'h00;
      address_enable_n   = 1'b1;
      reg_select         = 5'h00;
      io_read_n          = 1'b1;
      io_write_n         = 1'b1;
      dma_ack_n          = 1'b1;
   end

   // Only legal lane combinations are presented while selected
   task automatic setup(input logic sl, input logic bh, input logic ae, input logic [4:0] ba,
                        input logic [4:0] ad, input logic dk);
      @(posedge ref_clk);
      slot_width_sense   <= sl;
      high_byte_enable_n <= bh;
      address_enable_n   <= ae;
      base_addr_in       <= ba;
      reg_select         <= ad;
      dma_ack_n          <= dk;
   endtask : setup

   task automatic strobe(input logic wr, input logic [7:0] up, input logic [7:0] lo);
      @(posedge ref_clk);
      if (wr) begin
         host_upper <= up;
         host_lower <= lo;
         io_write_n <= 1'b0;
      end else begin
         io_read_n <= 1'b0;
      end
   endtask : strobe

   // Holds the strobe while channel ready is pulled low, then releases the strobes, address enable and DMA acknowledge
   task automatic finish;
      int n;
      n = 0;
      @(posedge ref_clk);
      while (chan_ready_oe_n === 1'b0 && n < 40) begin
         n++;
         @(posedge ref_clk);
      end
      io_read_n  <= 1'b1;
      io_write_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      host_upper       <= ~host_upper;
      host_lower       <= ~host_lower;
      address_enable_n <= 1'b1;
      dma_ack_n        <= 1'b1;
   endtask : finish
endmodule : isahp_host_model

// ---- test/isa_slave_host_port_tb_top.sv ----
// Self-checking bench for the ISA slave host port with a host model and a register file stub.
// Assumes the design and its package are compiled first.
`timescale 1ns/1ns

module isa_slave_host_port_tb_top;
   import isahp_pkg::*;
   localparam logic [4:0] SW = 5'h0B;
   logic             ref_clk, srst, legacy_mode, wr_ready;
   logic       [7:0] hu, hl, up_o, lo_o;
   logic             up_en_n, lo_en_n, bh_n, sl, ae_n, rd_n, wr_n, dk_n, cr_oe_n, wa_oe_n;
   logic       [4:0] ba, ad, rd_addr, rd_done_addr;
   logic             rd_req, rd_done, wr_valid, cr_o, wa_o;
   isahp_rd_s        rd_data;
   isahp_wr_s        wr_word;
   isahp_wr_s        got_q[$];
   isahp_wr_s        exp_q[$];
   int               err_total, compares;
   // Row layout: slot, byte enable, offset[4:0], write, upper lane used, lower lane used
   logic       [9:0] rows [10] = '{10'h0C3, 10'h0C7, 10'h01A, 10'h02E, 10'h111,
                                   10'h125, 10'h331, 10'h355, 10'h339, 10'h36D};

   assign rd_data = '{upper: {3'h5, rd_addr}, lower: {3'h2, rd_addr}};

   isahp_host_model isahp_host_model_inst (.ref_clk(ref_clk), .chan_ready_oe_n(cr_oe_n), .host_upper(hu),
      .host_lower(hl), .high_byte_enable_n(bh_n), .slot_width_sense(sl), .base_addr_in(ba),
      .address_enable_n(ae_n), .reg_select(ad), .io_read_n(rd_n), .io_write_n(wr_n), .dma_ack_n(dk_n));

   isahp_port isahp_port_inst (.ref_clk(ref_clk), .srst(srst),
      .upper_data_lane_i(up_en_n === 1'b0 ? up_o : hu), .lower_data_lane_i(lo_en_n === 1'b0 ? lo_o : hl),
      .upper_data_lane_o(up_o), .lower_data_lane_o(lo_o), .upper_lane_drive_en_n(up_en_n),
      .lower_lane_drive_en_n(lo_en_n), .high_byte_enable_n(bh_n), .slot_width_sense(sl),
      .base_addr_in(ba), .base_select_switch(SW), .address_enable_n(ae_n), .reg_select(ad),
      .io_read_n(rd_n), .io_write_n(wr_n), .dma_ack_n(dk_n), .legacy_mode(legacy_mode),
      .chan_ready_o(cr_o), .chan_ready_oe_n(cr_oe_n), .wide_cycle_ack_n_o(wa_o), .wide_cycle_ack_oe_n(wa_oe_n),
      .rd_addr(rd_addr), .rd_req(rd_req), .rd_data(rd_data), .rd_done(rd_done), .rd_done_addr(rd_done_addr),
      .wr_word(wr_word), .wr_valid(wr_valid), .wr_ready(wr_ready));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) if (wr_valid === 1'b1 && wr_ready === 1'b1) got_q.push_back(wr_word);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      if (err_total == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run

   task automatic do_read(input logic [9:0] r, input logic ae, input logic [4:0] b, input logic dk,
                          input logic [4:0] ea);
      isahp_host_model_inst.setup(r[9], r[8], ae, b, r[7:3], dk);
      isahp_host_model_inst.strobe(1'b0, 8'h00, 8'h00);
      repeat (5) @(posedge ref_clk);
      #1;
      check({up_en_n, lo_en_n}, {!r[1], !r[0]});
      check(up_o, r[1] ? {3'h5, ea} : 8'h00);
      check(lo_o, r[0] ? {3'h2, ea} : 8'h00);
      check(wa_oe_n, !r[1]);
      check(cr_oe_n, 1'b1);
      if (r[1] | r[0]) check({rd_req, rd_addr}, {1'b1, ea});
      isahp_host_model_inst.finish();
      @(posedge ref_clk);
      #1;
      if (r[1] | r[0]) check({rd_done, rd_done_addr}, {1'b1, ea});
      else check(rd_done, 1'b0);
      check({cr_o, wa_o}, 2'b00);
      repeat (3) @(posedge ref_clk);
      #1;
      check({up_en_n, lo_en_n, up_o, lo_o}, 18'h30000);
   endtask : do_read

   task automatic do_write(input logic [9:0] r, input logic ae, input logic [4:0] b, input logic dk,
                           input logic [4:0] ea, input logic [7:0] up, input logic [7:0] lo, input logic stall);
      isahp_wr_s e;
      e = '{addr: ea, upper: r[1] ? up : 8'h00, lower: r[0] ? lo : 8'h00, up_en: r[1], lo_en: r[0]};
      if (r[1] | r[0]) exp_q.push_back(e);
      isahp_host_model_inst.setup(r[9], r[8], ae, b, r[7:3], dk);
      isahp_host_model_inst.strobe(1'b1, up, lo);
      repeat (5) @(posedge ref_clk);
      #1;
      check(wa_oe_n, !r[1]);
      check({up_en_n, lo_en_n}, 2'b11);
      check(cr_oe_n, !stall);
      if (stall) @(posedge ref_clk) wr_ready <= 1'b1;
      isahp_host_model_inst.finish();
   endtask : do_write

   task automatic drain_check;
      int n;
      for (n = 0; n < 20 && got_q.size() < exp_q.size(); n++) @(posedge ref_clk);
      repeat (3) @(posedge ref_clk);
      check(got_q.size(), exp_q.size());
      while (got_q.size() > 0 && exp_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
   endtask : drain_check

   initial begin
      srst = 1'b1;
      legacy_mode = 1'b0;
      wr_ready = 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      foreach (rows[i]) begin
         if (rows[i][2]) do_write(rows[i], 1'b0, SW, 1'b1, rows[i][7:3], {4'hA, i[3:0]}, {4'h5, i[3:0]}, 1'b0);
         else do_read(rows[i], 1'b0, SW, 1'b1, rows[i][7:3]);
      end
      drain_check();
      // Deselected by base mismatch or by address enable
      do_read(10'h110, 1'b0, SW ^ 5'h01, 1'b1, 5'h02);
      do_read(10'h110, 1'b1, SW, 1'b1, 5'h02);
      do_write(10'h114, 1'b0, SW ^ 5'h10, 1'b1, 5'h02, 8'h81, 8'h18, 1'b0);
      // DMA ignores select, base and register bits
      do_read(10'h31B, 1'b1, SW ^ 5'h03, 1'b0, 5'h18);
      do_write(10'h31F, 1'b1, SW, 1'b0, 5'h18, 8'h96, 8'h69, 1'b0);
      drain_check();
      // Legacy offset lengthens the read; word offset does not
      @(posedge ref_clk) legacy_mode <= 1'b1;
      isahp_host_model_inst.setup(1'b0, 1'b0, 1'b0, SW, 5'h1B, 1'b1);
      isahp_host_model_inst.strobe(1'b0, 8'h00, 8'h00);
      repeat (4) @(posedge ref_clk);
      #1;
      check(cr_oe_n, 1'b0);
      repeat (4) @(posedge ref_clk);
      #1;
      check({cr_oe_n, up_o}, {1'b1, 3'h5, 5'h1B});
      isahp_host_model_inst.finish();
      do_read(10'h0C3, 1'b0, SW, 1'b1, 5'h18);
      @(posedge ref_clk) legacy_mode <= 1'b0;
      // Buffer fills while the consumer stalls, third write is held off
      @(posedge ref_clk) wr_ready <= 1'b0;
      do_write(10'h125, 1'b0, SW, 1'b1, 5'h04, 8'h11, 8'h01, 1'b0);
      do_write(10'h02E, 1'b0, SW, 1'b1, 5'h05, 8'h80, 8'h22, 1'b0);
      check(wr_valid, 1'b1);
      do_write(10'h0C7, 1'b0, SW, 1'b1, 5'h18, 8'h7E, 8'hE7, 1'b1);
      drain_check();
      // Reset in mid-read releases the lanes
      isahp_host_model_inst.setup(1'b0, 1'b0, 1'b0, SW, 5'h18, 1'b1);
      isahp_host_model_inst.strobe(1'b0, 8'h00, 8'h00);
      repeat (5) @(posedge ref_clk);
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      check({up_en_n, lo_en_n, wr_valid}, 3'b110);
      isahp_host_model_inst.finish();
      srst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      do_read(10'h0C3, 1'b0, SW, 1'b1, 5'h18);
      complete_run();
   end

   initial begin
      repeat (5000) @(posedge ref_clk);
      err_total++;
      complete_run();
   end
endmodule : isa_slave_host_port_tb_top
